// ---- inc/engine_link_pkg.sv ----
// Constants, types and settings layout for the engine controller interface.
package engine_link_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS      = 5000;    // System clock, 200 MHz.
	localparam int LINE_PERIOD_600_NS = 361820;  // Line sync period, 600 dpi.
	localparam int LINE_PERIOD_1200_NS = 180910; // Line sync period, 1200 dpi.
	localparam int LINE_LOW_NS        = 1000;    // Low time of each pulse.
	localparam int LINE_600_CYC  = LINE_PERIOD_600_NS * 1000 / CLK_PERIOD_PS;
	localparam int LINE_1200_CYC = LINE_PERIOD_1200_NS * 1000 / CLK_PERIOD_PS;
	localparam int LINE_LOW_CYC  = (LINE_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int LINE_CNT_W    = 17;           // Holds the longest period.

	// ------------------------------------------------------------------
	// Serial word
	// ------------------------------------------------------------------
	localparam int WORD_BITS   = 8;              // Bits per command or status.
	localparam int STAT_DATA_W = 6;              // Data bits of a status.

	// ------------------------------------------------------------------
	// Engine settings and their power-on values
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       scanner_idle;   // Scanner condition at idle setting.
		logic       fuser_idle;     // Fuser condition at idle setting.
		logic [1:0] out_tray;       // Selected output tray.
		logic       bad_page_hold;  // Bad-page hold mode engaged.
		logic       size_check;     // Paper-size mismatch checking on.
	} engine_settings_t;

	localparam logic [1:0] DEFAULT_OUTPUT_TRAY = 2'h0;
	localparam engine_settings_t SETTINGS_RESET = '{
		scanner_idle : 1'b1,
		fuser_idle   : 1'b1,
		out_tray     : DEFAULT_OUTPUT_TRAY,
		bad_page_hold: 1'b0,
		size_check   : 1'b0
	};

	// Sys-side reply sequencer states; each step flips one bit except DONE to IDLE, which flips both.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_DONE = 2'b11
	} reply_state_t;

endpackage

// ---- core/engine_link.sv ----
// Engine side of the controller signal interface: serial link, handshakes, sync.
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Controller supplies the serial shift clock
// [R2] Controller aligns pixels to page/line sync
// [R3] Pixels at 17.62726 Mpixel/s at 600 dpi
// [R4] Pixels at 70.50902 Mpixel/s at 1200 dpi
// [R5] Controller power-good low after its initialisation
// [R6] Host power-good high forces idle, default tray
// [R7] Host power-good high releases hold, checking off
// [R8] Controller holds command-active low while sending
// [R9] Status shifted out on host clock, reply-active low
// [R10] Engine drives active-low page sync per page
// [R11] Engine power-good low after own initialisation
// [R12] Stage request feeds one sheet, holds for start
// [R13] Stage request honoured only while feed-accept low
// [R14] Line sync period 361.82 or 180.91 us
// [R15] Reply-active low for whole status byte
// [R16] Feed-accept high ignores stage and start
// [R17] Eight bit words, MSB first, odd parity
// [R18] Launch on falling, sample on rising edge
// [R19] Controller inputs pass two-stage synchronisers
module engine_link #(
	parameter int LINE_CYC_600  = engine_link_pkg::LINE_600_CYC,
	parameter int LINE_CYC_1200 = engine_link_pkg::LINE_1200_CYC
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       arst_n_i,
	input  wire logic                       host_shift_clock_i,
	input  wire logic                       host_cmd_line_i,
	input  wire logic                       host_cmd_active_n_i,
	input  wire logic                       host_power_good_n_i,
	input  wire logic                       paper_stage_request_n_i,
	input  wire logic                       host_start_n_i,
	input  wire logic                       pixel_stream_i,
	output logic                            engine_reply_line_o,
	output logic                            engine_reply_active_n_o,
	output logic                            engine_power_good_n_o,
	output logic                            feed_accept_n_o,
	output logic                            page_sync_n_o,
	output logic                            line_sync_n_o,
	input  wire logic                       engine_init_done_i,
	input  wire logic                       engine_ready_i,
	input  wire logic                       hi_res_i,
	output logic                            cmd_valid_o,
	output logic [engine_link_pkg::WORD_BITS-1:0] cmd_byte_o,
	output logic                            cmd_parity_err_o,
	input  wire logic                       status_valid_i,
	input  wire logic [engine_link_pkg::STAT_DATA_W-1:0] status_data_i,
	output logic                            status_ready_o,
	input  wire logic                       settings_wr_i,
	input  wire engine_link_pkg::engine_settings_t settings_i,
	output engine_link_pkg::engine_settings_t settings_o,
	output logic                            stage_feed_o,
	input  wire logic                       stage_done_i,
	output logic                            start_print_o,
	output logic                            pixel_o
);
	import engine_link_pkg::*;

	// Odd parity holds when the XOR of all bits is one.
	function automatic logic odd_ok(input logic [WORD_BITS-1:0] w);
		odd_ok = ^w;
	endfunction

	// ------------------------------------------------------------------
	// Link domain: command receive on rising edges
	// ------------------------------------------------------------------
	logic [WORD_BITS-1:0] rx_shift_r;  // Incoming bits, MSB first.
	logic [2:0]           rx_cnt_r;    // Bits taken in this word.
	logic [WORD_BITS-1:0] rx_byte_r;   // Last whole word, held for sys.
	logic                 rx_tgl_r;    // Flips once per whole word.
	wire  [WORD_BITS-1:0] rx_word = {rx_shift_r[WORD_BITS-2:0],
		host_cmd_line_i};

	// The command-active line comes from the same party as the clock,
	// so it is taken on that clock directly; a partial word is dropped.
	always_ff @(posedge host_shift_clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_shift_r <= '0;
			rx_cnt_r   <= '0;
			rx_byte_r  <= '0;
			rx_tgl_r   <= 1'b0;
		end else if (host_cmd_active_n_i) begin
			rx_cnt_r <= '0;
		end else begin
			rx_shift_r <= rx_word;              // [R18]
			rx_cnt_r   <= rx_cnt_r + 3'h1;      // [R17]
			if (rx_cnt_r == 3'h7) begin
				rx_byte_r <= rx_word;
				rx_tgl_r  <= ~rx_tgl_r;
			end
		end
	end

	// ------------------------------------------------------------------
	// Link domain: status launch on falling edges
	// ------------------------------------------------------------------
	logic [2:0]           tx_cnt_r;    // Bit now on the reply line.
	logic                 tx_tgl_r;    // Flips once per sent status.
	logic [WORD_BITS-1:0] tx_byte_r;   // Sys-held status, stable in send.
	reply_state_t         st_r;

	// Status clocks only come while command-active is high, so the
	// counter starts each status at zero after a whole word.
	always_ff @(negedge host_shift_clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_cnt_r <= '0;
			tx_tgl_r <= 1'b0;
		end else if (host_cmd_active_n_i) begin
			tx_cnt_r <= tx_cnt_r + 3'h1;        // [R18]
			if (tx_cnt_r == 3'h7) begin
				tx_tgl_r <= ~tx_tgl_r;          // [R9]
			end
		end
	end

	// The first bit must stand before the first edge, so the line is a
	// select from held bits; idle level is high.
	wire tx_bit = tx_byte_r[3'h7 - tx_cnt_r];   // [R17]
	assign engine_reply_line_o = (st_r == ST_SEND) ? tx_bit : 1'b1;

	// ------------------------------------------------------------------
	// Synchronisers into the system clock
	// ------------------------------------------------------------------
	localparam int NSYNC = 6;
	wire  [NSYNC-1:0] sync_in = {host_power_good_n_i, host_cmd_active_n_i,
		paper_stage_request_n_i, host_start_n_i, rx_tgl_r, tx_tgl_r};
	logic [NSYNC-1:0] meta_r;     // First stage, read only by second.
	logic [NSYNC-1:0] sync_r;     // Second stage, safe to use.
	logic [NSYNC-1:0] sync_d_r;   // Previous value for edge detect.

	// Sync resets to the idle (high) levels of the active-low pins.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r   <= 6'h3C;
			sync_r   <= 6'h3C;
			sync_d_r <= 6'h3C;
		end else begin
			meta_r   <= sync_in;                // [R19]
			sync_r   <= meta_r;                 // [R19]
			sync_d_r <= sync_r;
		end
	end

	wire hpg_off   = sync_r[5];
	wire cmd_idle  = sync_r[4];
	wire stage_req = !sync_r[3] && sync_d_r[3];
	wire start_req = !sync_r[2] && sync_d_r[2];
	wire rx_evt    = sync_r[1] ^ sync_d_r[1];
	wire tx_evt    = sync_r[0] ^ sync_d_r[0];

	// ------------------------------------------------------------------
	// Received commands toward the engine logic
	// ------------------------------------------------------------------
	// The word is read only after its toggle has crossed, so it is stable.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_valid_o      <= 1'b0;
			cmd_byte_o       <= '0;
			cmd_parity_err_o <= 1'b0;
		end else begin
			cmd_valid_o <= rx_evt;
			if (rx_evt) begin
				cmd_byte_o       <= rx_byte_r;
				cmd_parity_err_o <= !odd_ok(rx_byte_r); // [R17]
			end
		end
	end

	// ------------------------------------------------------------------
	// Reply sequencer
	// ------------------------------------------------------------------
	wire reply_go = status_valid_i && cmd_idle && !hpg_off;
	wire [WORD_BITS-2:0] stat_hi = {1'b0, status_data_i};
	assign status_ready_o = (st_r == ST_IDLE) && cmd_idle && !hpg_off;

	// Reply-active falls only with the held byte in place and rises only
	// after the link reports all eight bits gone.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r      <= ST_IDLE;
			tx_byte_r <= '0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (reply_go) begin
						tx_byte_r <= {stat_hi, ~^stat_hi}; // [R17]
						st_r      <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (tx_evt) begin
						st_r <= ST_DONE;        // [R15]
					end
				end
				ST_DONE: begin
					st_r <= ST_IDLE;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end
	assign engine_reply_active_n_o = (st_r != ST_SEND); // [R9]

	AST_REPLY_HELD: assert property (@(posedge clk_sys_i) // [R15]
		disable iff (!arst_n_i)
		(st_r == ST_SEND && !tx_evt) |=> !engine_reply_active_n_o) // [R15]
		else $error("reply-active released before the status ended");
	AST_REPLY_PARITY: assert property (@(posedge clk_sys_i) // [R9]
		disable iff (!arst_n_i)
		$fell(engine_reply_active_n_o) |-> odd_ok(tx_byte_r)
			&& !tx_byte_r[7] && $past(reply_go)) // [R9]
		else $error("status sent with bad parity or without request");

	// ------------------------------------------------------------------
	// Power handshakes and settings
	// ------------------------------------------------------------------
	// Host power-good high wins over any settings write.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			settings_o            <= SETTINGS_RESET;
			engine_power_good_n_o <= 1'b1;
		end else begin
			engine_power_good_n_o <= !engine_init_done_i; // [R11]
			if (hpg_off) begin
				settings_o <= SETTINGS_RESET;   // [R6] [R7]
			end else if (settings_wr_i) begin
				settings_o <= settings_i;
			end
		end
	end

	AST_PG_IDLE: assert property (@(posedge clk_sys_i) // [R6]
		disable iff (!arst_n_i)
		hpg_off |=> settings_o.scanner_idle && settings_o.fuser_idle
			&& settings_o.out_tray == DEFAULT_OUTPUT_TRAY) // [R6]
		else $error("defaults not forced while host power is off");
	AST_PG_HOLD: assert property (@(posedge clk_sys_i) // [R7]
		disable iff (!arst_n_i)
		hpg_off |=> !settings_o.bad_page_hold && !settings_o.size_check) // [R7]
		else $error("hold or size check left on while host power is off");
	AST_ENGINE_PG: assert property (@(posedge clk_sys_i) // [R11]
		disable iff (!arst_n_i)
		$rose(engine_init_done_i) |=> !engine_power_good_n_o) // [R11]
		else $error("engine power-good not low after initialisation");

	// ------------------------------------------------------------------
	// Paper staging and start
	// ------------------------------------------------------------------
	logic staged_r;   // A sheet waits before registration.
	logic feeding_r;  // A sheet is on its way to staging.
	assign feed_accept_n_o = !(engine_ready_i && !engine_power_good_n_o);
	wire stage_ok = stage_req && !feed_accept_n_o && !staged_r && !feeding_r;
	wire start_ok = start_req && !feed_accept_n_o && staged_r;

	// Requests seen while feed-accept is high are simply dropped.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			staged_r      <= 1'b0;
			feeding_r     <= 1'b0;
			stage_feed_o  <= 1'b0;
			start_print_o <= 1'b0;
		end else begin
			stage_feed_o  <= stage_ok;          // [R13] [R16]
			start_print_o <= start_ok;          // [R16]
			if (stage_ok) begin
				feeding_r <= 1'b1;              // [R12]
			end else if (stage_done_i && feeding_r) begin
				feeding_r <= 1'b0;
			end
			if (stage_done_i && feeding_r) begin
				staged_r <= 1'b1;               // [R12]
			end else if (start_ok) begin
				staged_r <= 1'b0;
			end
		end
	end

	AST_STAGE_GATED: assert property (@(posedge clk_sys_i) // [R13]
		disable iff (!arst_n_i)
		stage_feed_o |-> $past(!feed_accept_n_o) && $past(stage_req)) // [R13]
		else $error("sheet staged while feed-accept was high");
	AST_START_STAGED: assert property (@(posedge clk_sys_i) // [R12]
		disable iff (!arst_n_i)
		start_print_o |-> $past(staged_r) && !staged_r) // [R12]
		else $error("start taken without a staged sheet");

	// ------------------------------------------------------------------
	// Line and page sync
	// ------------------------------------------------------------------
	logic [LINE_CNT_W-1:0] line_cnt_r; // Cycles into the current line.
	logic                  page_arm_r; // Page sync waits for next line.
	logic                  pix_meta_r; // First pixel stage, read by next.
	wire  [LINE_CNT_W-1:0] line_last = hi_res_i ?
		LINE_CNT_W'(LINE_CYC_1200 - 1) : LINE_CNT_W'(LINE_CYC_600 - 1);
	wire line_wrap = (line_cnt_r >= line_last);

	// Page sync is held for one whole line so that it brackets a line
	// sync pulse, which gives the host an unambiguous first line.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			// Start past the low window so no short pulse follows reset.
			line_cnt_r    <= LINE_CNT_W'(LINE_LOW_CYC - 1);
			line_sync_n_o <= 1'b1;
			page_arm_r    <= 1'b0;
			page_sync_n_o <= 1'b1;
			pixel_o       <= 1'b0;
			pix_meta_r    <= 1'b0;
		end else begin
			line_cnt_r    <= line_wrap ? '0 : line_cnt_r + 1'b1; // [R14]
			line_sync_n_o <= !(line_wrap
				|| line_cnt_r < LINE_CNT_W'(LINE_LOW_CYC - 1));
			pix_meta_r    <= pixel_stream_i;    // [R19]
			pixel_o       <= pix_meta_r;        // [R19]
			if (start_ok) begin
				page_arm_r <= 1'b1;
			end else if (line_wrap && page_arm_r) begin
				page_arm_r    <= 1'b0;
				page_sync_n_o <= 1'b0;          // [R10]
			end else if (line_wrap) begin
				page_sync_n_o <= 1'b1;
			end
		end
	end

	AST_LINE_PERIOD: assert property (@(posedge clk_sys_i) // [R14]
		disable iff (!arst_n_i)
		$fell(line_sync_n_o)
			|-> $past(line_cnt_r) >= $past(line_last)) // [R14]
		else $error("line sync period wrong");
	AST_PAGE_ALIGN: assert property (@(posedge clk_sys_i) // [R10]
		disable iff (!arst_n_i)
		$fell(page_sync_n_o) |-> $fell(line_sync_n_o)) // [R10]
		else $error("page sync not aligned to line sync");

endmodule

// ---- sim/host_ctrl_model.sv ----
// Behavioural host controller that drives the engine's serial link.
`timescale 1ns/100ps
module host_ctrl_model (
	output logic      host_shift_clock_o,
	output logic      host_cmd_line_o,
	output logic      host_cmd_active_n_o,
	output logic      pixel_stream_o,
	input  wire logic engine_reply_line_i,
	input  wire logic engine_reply_active_n_i
);
	localparam time HALF = 32; // Half of the 64 ns link clock.

	// The link clock rests low between frames; it never runs free.
	initial begin
		host_shift_clock_o = 1'h0;
		host_cmd_line_o = 1'h1;
		host_cmd_active_n_o = 1'h1;
		pixel_stream_o = 1'h0;
	end

	// ------------------------------------------------------------
	// Send one command word; bits change only while the clock is low.
	// ------------------------------------------------------------
	task send_cmd(input logic [7:0] b);
		host_cmd_active_n_o = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			host_cmd_line_o = b[i];
			#HALF host_shift_clock_o = 1'h1;
			#HALF host_shift_clock_o = 1'h0;
		end
		#HALF host_cmd_active_n_o = 1'h1;
		// A released line shows the inverse, so stale data never matches.
		host_cmd_line_o = ~b[0];
	endtask

	// Clock exactly eight status bits, sampling on each rising edge.
	task read_status(output logic [7:0] b, output logic ok);
		ok = 1'h1;
		for (int i = 7; i >= 0; i--) begin
			#HALF host_shift_clock_o = 1'h1;
			b[i] = engine_reply_line_i;
			ok = ok & ~engine_reply_active_n_i;
			#HALF host_shift_clock_o = 1'h0;
		end
	endtask

	// Hold one pixel for one pixel time; the pitch sets the rate.
	task send_pixel(input logic v, input real pitch);
		pixel_stream_o = v;
		#(pitch);
	endtask
endmodule

// ---- sim/test_engine_link.sv ----
// Self-checking bench for the engine side of the controller interface.
`timescale 1ns/100ps
module test_engine_link;
	import engine_link_pkg::*;
	localparam int L600  = 400; // Short line period, normal resolution.
	localparam int L1200 = 300; // Short line period, high resolution.
	localparam real PIX_600_NS  = 1000.0 / 17.62726; // Pixel time, 600 dpi.
	localparam real PIX_1200_NS = 1000.0 / 70.50902; // Pixel time, 1200 dpi.
	logic             clk_sys_i, arst_n_i, sclk, cmd_line, cmd_act_n;
	logic             host_pg_n, stage_n, start_n, init_done, eng_ready;
	logic             hi_res, stat_valid, settings_wr, stage_done;
	logic [5:0]       stat_data;
	engine_settings_t set_in, set_out;
	logic             reply, reply_act_n, pg_n, feed_n, page_n, line_n;
	logic             cmd_valid, cmd_perr, stat_ready, stage_feed;
	logic             start_pr, pix, pix_line;
	logic [7:0]       cmd_byte;
	int               errors, n_checks;

	host_ctrl_model host (.host_shift_clock_o(sclk),
		.host_cmd_line_o(cmd_line), .host_cmd_active_n_o(cmd_act_n),
		.engine_reply_line_i(reply), .engine_reply_active_n_i(reply_act_n),
		.pixel_stream_o(pix_line));

	engine_link #(.LINE_CYC_600(L600), .LINE_CYC_1200(L1200)) dut (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.host_shift_clock_i(sclk), .host_cmd_line_i(cmd_line),
		.host_cmd_active_n_i(cmd_act_n), .host_power_good_n_i(host_pg_n),
		.paper_stage_request_n_i(stage_n), .host_start_n_i(start_n),
		.pixel_stream_i(pix_line), .engine_reply_line_o(reply),
		.engine_reply_active_n_o(reply_act_n),
		.engine_power_good_n_o(pg_n), .feed_accept_n_o(feed_n),
		.page_sync_n_o(page_n), .line_sync_n_o(line_n),
		.engine_init_done_i(init_done), .engine_ready_i(eng_ready),
		.hi_res_i(hi_res), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
		.cmd_parity_err_o(cmd_perr), .status_valid_i(stat_valid),
		.status_data_i(stat_data), .status_ready_o(stat_ready),
		.settings_wr_i(settings_wr), .settings_i(set_in),
		.settings_o(set_out), .stage_feed_o(stage_feed),
		.stage_done_i(stage_done), .start_print_o(start_pr), .pixel_o(pix));

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task complete_run();
		if (errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Four-state compare, so an unknown never passes.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait; running out is a mismatch and ends the run.
	task automatic wait_on(ref logic s, input logic v, input int n);
		int i;
		for (i = 0; i < n && s !== v; i++)
			@(negedge clk_sys_i);
		chk(s, v);
		if (s !== v) complete_run();
	endtask

	task automatic stays(ref logic s, input logic v, input int n);
		repeat (n) begin
			@(negedge clk_sys_i);
			chk(s, v);
		end
	endtask

	task pulse_wr();
		settings_wr = 1'h1;
		@(negedge clk_sys_i);
		settings_wr = 1'h0;
		@(negedge clk_sys_i);
	endtask

	// Count cycles up to the next falling edge of line sync.
	task fall(output int n);
		n = 0;
		while (line_n !== 1'h1 && n < 1000) begin
			@(negedge clk_sys_i);
			n++;
		end
		while (line_n !== 1'h0 && n < 1000) begin
			@(negedge clk_sys_i);
			n++;
		end
		// Running out of cycles is a mismatch and ends the run.
		if (n >= 1000) begin
			chk(n, 0);
			complete_run();
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_power();
		chk(set_out, SETTINGS_RESET);
		chk({reply, reply_act_n, pg_n}, 3'h7);
		init_done = 1'h1;
		wait_on(pg_n, 1'h0, 4);
		host_pg_n = 1'h0;
		// The level must cross the synchroniser before a write can land.
		repeat (4) @(negedge clk_sys_i);
	endtask

	// Host power-good high must win over a settings write.
	task t_settings();
		set_in = '{1'h0, 1'h0, 2'h3, 1'h1, 1'h1};
		pulse_wr();
		chk(set_out, set_in);
		host_pg_n = 1'h1;
		repeat (4) @(negedge clk_sys_i);
		chk(set_out, SETTINGS_RESET);
		pulse_wr();
		chk(set_out, SETTINGS_RESET);
		host_pg_n = 1'h0;
		repeat (4) @(negedge clk_sys_i);
	endtask

	task t_link(input logic [7:0] c, input logic [5:0] d);
		logic [7:0] got;
		logic       ok;
		fork
			host.send_cmd(c);
			wait_on(cmd_valid, 1'h1, 200);
		join
		chk(cmd_byte, c);
		chk(cmd_perr, ~^c);
		// The word ends off the system clock; drive again at a falling edge.
		@(negedge clk_sys_i);
		stat_data = d;
		stat_valid = 1'h1;
		wait_on(stat_ready, 1'h1, 20);
		@(negedge clk_sys_i);
		stat_valid = 1'h0;
		wait_on(reply_act_n, 1'h0, 4);
		host.read_status(got, ok);
		chk(got, {1'h0, d, ~^d});
		chk(ok, 1'h1);
		wait_on(reply_act_n, 1'h1, 20);
	endtask

	// Pixels cross two stages; each must show before the next arrives.
	task t_pixel(input real pitch);
		for (int i = 0; i < 4; i++) begin
			host.send_pixel(!i[0], pitch);
			chk(pix, !i[0]);
		end
		@(negedge clk_sys_i);
	endtask

	// Requests while feed-accept is high must vanish without effect.
	task t_stage();
		chk(feed_n, 1'h1);
		stage_n = 1'h0;
		stays(stage_feed, 1'h0, 10);
		start_n = 1'h0;
		stays(start_pr, 1'h0, 10);
		stage_n = 1'h1;
		start_n = 1'h1;
		eng_ready = 1'h1;
		repeat (4) @(negedge clk_sys_i);
		chk(feed_n, 1'h0);
		stage_n = 1'h0;
		wait_on(stage_feed, 1'h1, 10);
		stage_done = 1'h1;
		@(negedge clk_sys_i);
		stage_done = 1'h0;
		start_n = 1'h0;
		wait_on(start_pr, 1'h1, 10);
		wait_on(page_n, 1'h0, 900);
		chk(line_n, 1'h0);
		stage_n = 1'h1;
		start_n = 1'h1;
	endtask

	task t_line(input logic hr, input int per);
		int n;
		hi_res = hr;
		fall(n);
		fall(n);
		fall(n);
		chk(n, per);
	endtask

	initial begin
		clk_sys_i = 1'h0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// Main sequence: reset for two cycles, then every scenario in turn.
	initial begin
		errors = 0;
		n_checks = 0;
		{arst_n_i, init_done, eng_ready, hi_res, stat_valid} = 5'h0;
		{settings_wr, stage_done, stat_data} = 8'h0;
		{host_pg_n, stage_n, start_n} = 3'h7;
		set_in = SETTINGS_RESET;
		repeat (2) @(negedge clk_sys_i);
		arst_n_i = 1'h1;
		repeat (3) @(negedge clk_sys_i);
		t_power();
		t_settings();
		t_link(8'h02, 6'h2A);
		t_link(8'h03, 6'h00);
		t_stage();
		t_line(1'h0, L600);
		t_line(1'h1, L1200);
		t_pixel(PIX_600_NS);
		t_pixel(PIX_1200_NS);
		complete_run();
	end
endmodule
